// ---- design/ram_guard_pkg.sv ----
package ram_guard_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 22;
  localparam int CPU_AW = 20;
  localparam int RAM_AW = 12;
  localparam int EV_W   = 2;

  // RAM window seen by the CPU
  localparam logic [CPU_AW-1:0] RAM_BASE = 20'hfe000;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ACCESS_GUARD = 22'h0f0078;
  localparam logic [IDX_W-1:0] IDX_PARITY_CTRL  = 22'h0f00f5;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 22'h0f0100;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK     = 22'h0f0101;
  localparam logic [IDX_W-1:0] IDX_RESET_CAUSE  = 22'h0f0102;

  localparam logic [7:0] REG_RESET = 8'h00;

  // access_guard_control fields
  localparam int AG_DETECT_BIT = 7;
  localparam int AG_SIZE_HI    = 5;
  localparam int AG_SIZE_LO    = 4;
  localparam int AG_PORT_BIT   = 2;
  localparam int AG_IRQ_BIT    = 1;
  localparam int AG_SYS_BIT    = 0;
  localparam logic [7:0] AG_WMASK  = 8'hb7;
  localparam logic [7:0] AG_STICKY = 8'h80;

  // ram_parity_control fields
  localparam int PC_MASK_BIT = 7;
  localparam int PC_FLAG_BIT = 0;

  // Event bits of irq status and mask
  localparam int EV_PARITY  = 0;
  localparam int EV_ILLEGAL = 1;

  // reset_cause_register bits
  localparam int CAUSE_ILLEGAL = 0;
  localparam int CAUSE_PARITY  = 1;

  // Guarded region sizes in bytes
  localparam logic [RAM_AW-1:0] GUARD_NONE = 12'h000;
  localparam logic [RAM_AW-1:0] GUARD_128  = 12'h080;
  localparam logic [RAM_AW-1:0] GUARD_256  = 12'h100;
  localparam logic [RAM_AW-1:0] GUARD_512  = 12'h200;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KIND_NONE      = 3'h0,
    KIND_RAM       = 3'h1,
    KIND_PORT_CFG  = 3'h2,
    KIND_PORT_DATA = 3'h3,
    KIND_IRQ       = 3'h4,
    KIND_SYS_CTRL  = 3'h5,
    KIND_OTHER_SFR = 3'h6
  } access_kind_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_DATA = 2'h1
  } rd_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              fetch;
    access_kind_t      kind;
    logic [CPU_AW-1:0] addr;
    logic [7:0]        wdata;
  } cpu_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cpu_rsp_t;

  typedef struct packed {
    logic              en;
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [8:0]        wdata;
  } ram_req_t;

  typedef struct packed {
    logic              en;
    logic              we;
    logic [CPU_AW-1:0] addr;
    logic [7:0]        wdata;
  } sfr_req_t;

  typedef struct packed {
    wr_state_t         wr;
    rd_state_t         rd;
    logic              awReady;
    logic              wReady;
    logic              awGot;
    logic              wGot;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0]        wData;
    logic              wLane0;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0]        rResp;
    logic [7:0]        guardCtl;
    logic [7:0]        parityCtl;
    logic [EV_W-1:0]   irqStatus;
    logic [EV_W-1:0]   irqMask;
    logic [1:0]        cause;
    ram_req_t          ram;
    sfr_req_t          sfr;
    logic              pendRam;
    logic              pendChk;
    logic              pendSfr;
    cpu_rsp_t          rsp;
    logic              intReset;
    logic              irq;
  } state_t;

endpackage

// ---- design/ram_parity_and_write_guard.sv ----
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - Parity bit generated on each RAM byte write, checked on data read.
// - Parity error raises internal reset unless reset mask bit 7 set.
// - Parity error flag bit 0 reads one after an error, else zero.
// - Illegal access reset sets illegal access flag in reset cause.
// - Guarded RAM reads return data; writes dropped silently.
// - Guard size field: none, 128, 256 or 512 bytes from RAM base.
// - Detect enable sticks once set; only reset clears it.
// - Watchdog option forces illegal access detection on.
// - Detected illegal access with detection on raises internal reset.
// - Bit 7 of access guard control enables illegal access detection.
// - Port guard blocks port configuration writes, reads stay allowed.
// - Port output data registers stay writable always.
// - Interrupt guard blocks interrupt control writes, reads allowed.
// - System guard blocks clock, voltage and parity control writes.
// - Blocked writes leave target unchanged, no error, no reset.
// - Both control registers reset to zero.
module ram_parity_and_write_guard
  import ram_guard_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire cpu_req_t          cpuReq,
  output      cpu_rsp_t          cpuRsp,
  output      ram_req_t          ramReq,
  input  wire logic [8:0]        ramRdata,
  output      sfr_req_t          sfrReq,
  input  wire logic [7:0]        sfrRdata,
  input  wire logic              watchdogOptionOn,
  output      logic              intResetReq,
  output      logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                  input logic [IDX_W-1:0]  idx);
    regHit = (a[ADDR_W-1:2] == idx);
  endfunction

  // Stored bit makes every nine-bit RAM word even
  function automatic logic parityOf(input logic [7:0] d);
    parityOf = ^d;
  endfunction

  // Unknown targets, and fetches from anywhere but RAM
  function automatic logic isIllegal(input cpu_req_t r);
    isIllegal = (r.kind == KIND_NONE) ||
                (r.fetch && (r.kind != KIND_RAM));
  endfunction

  // Write one to clear; events are merged afterwards so a set wins
  function automatic logic [EV_W-1:0] w1c(input logic [EV_W-1:0] cur,
                                          input logic [EV_W-1:0] clr);
    w1c = cur & ~clr;
  endfunction

  function automatic logic [RAM_AW-1:0] guardSize(input logic [7:0] g);
    logic [1:0] sel;
    sel = {g[AG_SIZE_HI], g[AG_SIZE_LO]};
    case (sel)
      2'h1:    guardSize = GUARD_128;
      2'h2:    guardSize = GUARD_256;
      2'h3:    guardSize = GUARD_512;
      default: guardSize = GUARD_NONE;
    endcase
  endfunction

  // Guarded window always starts at the RAM base
  function automatic logic ramGuarded(input logic [RAM_AW-1:0] off,
                                      input logic [7:0]        g);
    ramGuarded = (off < guardSize(g));
  endfunction

  // Port data and other SFRs are never guarded
  function automatic logic sfrGuarded(input access_kind_t k,
                                      input logic [7:0]   g);
    case (k)
      KIND_PORT_CFG:  sfrGuarded = g[AG_PORT_BIT];
      KIND_PORT_DATA: sfrGuarded = 1'b0;
      KIND_IRQ:       sfrGuarded = g[AG_IRQ_BIT];
      KIND_SYS_CTRL:  sfrGuarded = g[AG_SYS_BIT];
      default:        sfrGuarded = 1'b0;
    endcase
  endfunction

  // Returns hit flag above the read word
  function automatic logic [DATA_W:0] regRead(input logic [ADDR_W-1:0] a,
                                              input state_t st);
    logic [DATA_W-1:0] d;
    logic              h;
    d = '0;
    h = 1'b1;
    if (regHit(a, IDX_ACCESS_GUARD)) begin
      d[7:0] = st.guardCtl;
    end else if (regHit(a, IDX_PARITY_CTRL)) begin
      d[7:0] = st.parityCtl;
    end else if (regHit(a, IDX_IRQ_STATUS)) begin
      d[EV_W-1:0] = st.irqStatus;
    end else if (regHit(a, IDX_IRQ_MASK)) begin
      d[EV_W-1:0] = st.irqMask;
    end else if (regHit(a, IDX_RESET_CAUSE)) begin
      d[1:0] = st.cause;
    end else begin
      h = 1'b0;
    end
    regRead = {h, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t s;
  state_t n;

  logic              evParity;
  logic              evIllegal;
  logic              detectOn;
  logic              illegal;
  logic [RAM_AW-1:0] ramOff;
  logic [DATA_W:0]   rdWord;
  logic              hit;

  always_comb begin
    n         = s;
    evParity  = 1'b0;
    evIllegal = 1'b0;
    detectOn  = s.guardCtl[AG_DETECT_BIT] | watchdogOptionOn;
    illegal   = 1'b0;
    ramOff    = '0;
    rdWord    = '0;
    hit       = 1'b0;

    // Pulses default low
    n.ram.en    = 1'b0;
    n.ram.we    = 1'b0;
    n.sfr.en    = 1'b0;
    n.sfr.we    = 1'b0;
    n.rsp.valid = 1'b0;
    n.intReset  = 1'b0;
    n.pendRam   = 1'b0;
    n.pendChk   = 1'b0;
    n.pendSfr   = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Read data returning from the targets

    if (s.pendRam) begin
      n.rsp.valid = 1'b1;
      n.rsp.data  = ramRdata[7:0];
      // Fetches skip the check: code bytes may hold stale parity
      if (s.pendChk &&
          (parityOf(ramRdata[7:0]) != ramRdata[8])) begin
        evParity = 1'b1;
      end
    end
    if (s.pendSfr) begin
      n.rsp.valid = 1'b1;
      n.rsp.data  = sfrRdata;
    end

    //////////////////////////////////////////////////////////////////////////
    // CPU accesses

    // One read at a time: a second would collide on cpuRsp
    if (cpuReq.valid) begin
      illegal = isIllegal(cpuReq);
      if (illegal) begin
        // Never forwarded; a read still answers so the CPU cannot hang
        evIllegal = 1'b1;
        if (!cpuReq.write) begin
          n.rsp.valid = 1'b1;
          n.rsp.data  = '0;
        end
      end else if (cpuReq.kind == KIND_RAM) begin
        ramOff = RAM_AW'(cpuReq.addr - RAM_BASE);
        if (cpuReq.write) begin
          if (!ramGuarded(ramOff, s.guardCtl)) begin
            n.ram.en    = 1'b1;
            n.ram.we    = 1'b1;
            n.ram.addr  = ramOff;
            n.ram.wdata = {parityOf(cpuReq.wdata), cpuReq.wdata};
          end
        end else begin
          n.ram.en   = 1'b1;
          n.ram.addr = ramOff;
          n.pendRam  = 1'b1;
          n.pendChk  = !cpuReq.fetch;
        end
      end else begin
        if (cpuReq.write) begin
          // Blocked write never reaches the target
          if (!sfrGuarded(cpuReq.kind, s.guardCtl)) begin
            n.sfr.en    = 1'b1;
            n.sfr.we    = 1'b1;
            n.sfr.addr  = cpuReq.addr;
            n.sfr.wdata = cpuReq.wdata;
          end
        end else begin
          n.sfr.en   = 1'b1;
          n.sfr.addr = cpuReq.addr;
          n.pendSfr  = 1'b1;
        end
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI write channel
    // Address and data come in either order; the first waits for the other

    case (s.wr)
      WR_IDLE: begin
        if (s_axi_awvalid && s.awReady) begin
          n.awGot  = 1'b1;
          n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wReady) begin
          n.wGot   = 1'b1;
          n.wData  = s_axi_wdata[7:0];
          n.wLane0 = s_axi_wstrb[0];
        end
        if (n.awGot && n.wGot) begin
          n.awGot  = 1'b0;
          n.wGot   = 1'b0;
          n.bValid = 1'b1;
          n.bResp  = RESP_OKAY;
          n.wr     = WR_RESP;
          if (regHit(n.awAddr, IDX_ACCESS_GUARD)) begin
            if (n.wLane0) begin
              // Detect enable can only be raised here
              n.guardCtl = (n.wData & AG_WMASK) |
                           (s.guardCtl & AG_STICKY);
            end
          end else if (regHit(n.awAddr, IDX_PARITY_CTRL)) begin
            if (n.wLane0 && !s.guardCtl[AG_SYS_BIT]) begin
              n.parityCtl[PC_MASK_BIT] = n.wData[PC_MASK_BIT];
              if (!n.wData[PC_FLAG_BIT]) begin
                n.parityCtl[PC_FLAG_BIT] = 1'b0;
              end
            end
          end else if (regHit(n.awAddr, IDX_IRQ_STATUS)) begin
            if (n.wLane0) begin
              n.irqStatus = w1c(s.irqStatus, n.wData[EV_W-1:0]);
            end
          end else if (regHit(n.awAddr, IDX_IRQ_MASK)) begin
            if (n.wLane0) begin
              n.irqMask = n.wData[EV_W-1:0];
            end
          end else if (regHit(n.awAddr, IDX_RESET_CAUSE)) begin
            if (n.wLane0) begin
              n.cause = w1c(s.cause, n.wData[1:0]);
            end
          end else begin
            n.bResp = RESP_SLVERR;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          n.bValid = 1'b0;
          n.wr     = WR_IDLE;
        end
      end
      default: begin
        n.wr     = WR_IDLE;
        n.bValid = 1'b0;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // AXI read channel
    // Data is captured at the handshake and held until rready

    case (s.rd)
      RD_IDLE: begin
        if (s_axi_arvalid && s.arReady) begin
          rdWord   = regRead(s_axi_araddr, s);
          hit      = rdWord[DATA_W];
          n.rData  = rdWord[DATA_W-1:0];
          n.rResp  = hit ? RESP_OKAY : RESP_SLVERR;
          n.rValid = 1'b1;
          n.rd     = RD_DATA;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          n.rValid = 1'b0;
          n.rd     = RD_IDLE;
        end
      end
      default: begin
        n.rd     = RD_IDLE;
        n.rValid = 1'b0;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Events; applied after software writes so a set wins over a clear

    if (evParity) begin
      n.parityCtl[PC_FLAG_BIT] = 1'b1;
      n.irqStatus[EV_PARITY]   = 1'b1;
      if (!s.parityCtl[PC_MASK_BIT]) begin
        n.intReset            = 1'b1;
        n.cause[CAUSE_PARITY] = 1'b1;
      end
    end
    if (evIllegal) begin
      n.irqStatus[EV_ILLEGAL] = 1'b1;
      if (detectOn) begin
        n.intReset             = 1'b1;
        n.cause[CAUSE_ILLEGAL] = 1'b1;
      end
    end

    // Readies follow the next state so a finished write reopens at once
    n.awReady = (n.wr == WR_IDLE) && !n.awGot;
    n.wReady  = (n.wr == WR_IDLE) && !n.wGot;
    n.arReady = (n.rd == RD_IDLE);
    n.irq     = |(n.irqStatus & n.irqMask);
  end

  // Clock enable freezes everything, including pending read checks
  always_ff @(posedge clk) begin
    if (reset) begin
      s           <= '0;
      s.guardCtl  <= REG_RESET;
      s.parityCtl <= REG_RESET;
    end else if (ce) begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Straight from the state register, no logic after the flops
  assign s_axi_awready = s.awReady;
  assign s_axi_wready  = s.wReady;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_arready = s.arReady;
  assign s_axi_rvalid  = s.rValid;
  assign s_axi_rdata   = s.rData;
  assign s_axi_rresp   = s.rResp;
  assign cpuRsp        = s.rsp;
  assign ramReq        = s.ram;
  assign sfrReq        = s.sfr;
  assign intResetReq   = s.intReset;
  assign irq           = s.irq;

endmodule

// ---- tb/ram_parity_and_write_guard_assertions.sv ----
`timescale 1ns/1ps
module guard_checker
  import ram_guard_pkg::*;
(
  input wire logic     clk,
  input wire logic     reset,
  input wire logic     ce,
  input wire cpu_req_t cpuReq,
  input wire cpu_rsp_t cpuRsp,
  input wire ram_req_t ramReq,
  input wire sfr_req_t sfrReq,
  input wire logic     watchdogOptionOn,
  input wire logic     intResetReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  logic illegal;
  assign take    = ce && cpuReq.valid;
  assign illegal = cpuReq.kind == KIND_NONE
                || (cpuReq.fetch && cpuReq.kind != KIND_RAM);
  //////////////////////////////////////////////////////////////////////////
  parity_gen_a: assert property (ramReq.en && ramReq.we |->
    ramReq.wdata[8] == ^ramReq.wdata[7:0])
    else $error("RAM parity bit wrong");
  ram_write_cause_a: assert property (ramReq.we |->
    $past(take && cpuReq.write && cpuReq.kind == KIND_RAM))
    else $error("RAM write without CPU write");
  ram_read_path_a: assert property (
    take && !cpuReq.write && cpuReq.kind == KIND_RAM |=>
    ramReq.en && !ramReq.we
    && ramReq.addr == 12'($past(cpuReq.addr) - RAM_BASE) ##1 cpuRsp.valid)
    else $error("RAM read path wrong");
  port_data_a: assert property (
    take && cpuReq.write && cpuReq.kind == KIND_PORT_DATA |=>
    sfrReq.en && sfrReq.we && sfrReq.wdata == $past(cpuReq.wdata))
    else $error("Port data write dropped");
  sfr_write_cause_a: assert property (sfrReq.we |->
    $past(take && cpuReq.write))
    else $error("SFR write without CPU write");
  wdog_reset_a: assert property (
    take && illegal && watchdogOptionOn |=> intResetReq)
    else $error("No reset on illegal access");
  illegal_block_a: assert property (take && illegal |=>
    !ramReq.en && !sfrReq.en
    && (!cpuRsp.valid || cpuRsp.data == 8'h00))
    else $error("Illegal access forwarded");
  reset_cause_a: assert property (intResetReq |->
    $past(take && illegal) || cpuRsp.valid)
    else $error("Reset without cause");
  cover property (intResetReq);
  cover property (ramReq.en && !ramReq.we ##1 cpuRsp.valid);
  cover property (sfrReq.en && sfrReq.we);
endmodule

bind ram_parity_and_write_guard guard_checker chk (
  .clk, .reset, .ce, .cpuReq, .cpuRsp, .ramReq, .sfrReq,
  .watchdogOptionOn, .intResetReq
);

// ---- tb/ram_parity_and_write_guard_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module ram_parity_and_write_guard_tb;
  import ram_guard_pkg::*;
  localparam logic [23:0] A_AG = {IDX_ACCESS_GUARD, 2'b00};
  localparam logic [23:0] A_PC = {IDX_PARITY_CTRL, 2'b00};
  localparam logic [23:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [23:0] A_MK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [23:0] A_RC = {IDX_RESET_CAUSE, 2'b00};
  logic        clk = 0;
  logic        reset = 1;
  logic        wdog = 0;
  logic        badPar = 0;
  logic [23:0] awaddr = 0;
  logic [23:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0;
  logic        wvalid = 0;
  logic        bready = 0;
  logic        arvalid = 0;
  logic        rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, intRst, irqO;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata;
  logic [7:0]  q, sfrD;
  logic [8:0]  ramD;
  cpu_req_t    req = '0;
  cpu_rsp_t    rsp;
  ram_req_t    ramQ;
  sfr_req_t    sfrQ;
  int          err_total = 0, checks = 0, rstSeen = 0, n;
  always #2 clk = ~clk;
  always @(posedge clk) if (intRst === 1'b1) rstSeen++;
  ram_parity_and_write_guard DUT (
    .clk, .reset, .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpuReq(req),
    .cpuRsp(rsp), .ramReq(ramQ), .ramRdata(ramD), .sfrReq(sfrQ),
    .sfrRdata(sfrD), .watchdogOptionOn(wdog), .intResetReq(intRst),
    .irq(irqO)
  );
  target_model far (.clk, .ramReq(ramQ), .sfrReq(sfrQ), .badParity(badPar),
    .ramRdata(ramD), .sfrRdata(sfrD));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic axw(logic [23:0] a, logic [7:0] d);
    logic ga, gw;
    ga = 0;
    gw = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      ga |= awready;
      gw |= wready;
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end while (!(ga && gw));
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(logic [23:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    q = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  // Every access waits a fixed four cycles; RAM and SFR reads answer equally late
  task automatic cpu(logic w, access_kind_t k, logic [19:0] a, logic [7:0] d,
                     logic f = 1'b0);
    q = 8'hee;
    req <= '{1'b1, w, f, k, a, d};
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      if (rsp.valid === 1'b1) q = rsp.data;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axr(A_AG); `CHK("guard reset", 8'h00, q);
    axr(A_PC); `CHK("parity reset", 8'h00, q);
    axr(24'h000010); `CHK("unmapped rd", RESP_SLVERR, r);
    axw(24'h000010, 8'h5a); `CHK("unmapped wr", RESP_SLVERR, r);
    $display("test reset done");
  endtask
  task automatic t_wdog;
    n = rstSeen;
    wdog <= 1'b1;
    cpu(1'b0, KIND_NONE, 20'h00100, 8'h00);
    `CHK("wdog reset", n + 1, rstSeen);
    `CHK("illegal data", 8'h00, q);
    wdog <= 1'b0;
    $display("test watchdog done");
  endtask
  task automatic t_illegal;
    axw(A_RC, 8'h03);
    axw(A_ST, 8'h03);
    n = rstSeen;
    cpu(1'b1, KIND_NONE, 20'h00200, 8'h00);
    `CHK("no detect", n, rstSeen);
    axr(A_ST); `CHK("irq status", 8'h02, q);
    `CHK("irq masked", 1'b0, irqO);
    axw(A_MK, 8'h02);
    repeat (2) @(posedge clk);
    `CHK("irq on", 1'b1, irqO);
    axw(A_ST, 8'h02);
    repeat (2) @(posedge clk);
    `CHK("irq clear", 1'b0, irqO);
    axw(A_AG, 8'h80);
    axw(A_AG, 8'h00);
    axr(A_AG); `CHK("detect sticky", 8'h80, q);
    cpu(1'b1, KIND_NONE, 20'h00200, 8'h00);
    `CHK("detect reset", n + 1, rstSeen);
    axr(A_RC); `CHK("reset cause", 8'h01, q);
    cpu(1'b0, KIND_SYS_CTRL, 20'hf0020, 8'h00, 1'b1);
    `CHK("sfr fetch", n + 2, rstSeen);
    `CHK("sfr fetch data", 8'h00, q);
    axw(A_MK, 8'h00);
    $display("test illegal done");
  endtask
  task automatic t_ramguard;
    logic [19:0] lo, hi;
    n = rstSeen;
    for (int g = 1; g < 4; g++) begin
      hi = RAM_BASE + (20'h40 << g);
      lo = hi - 20'h1;
      axw(A_AG, 8'h80);
      cpu(1'b1, KIND_RAM, lo, 8'h11);
      cpu(1'b1, KIND_RAM, hi, 8'h22);
      axw(A_AG, 8'h80 | 8'(g << 4));
      cpu(1'b1, KIND_RAM, lo, 8'h33);
      cpu(1'b1, KIND_RAM, hi, 8'h44);
      cpu(1'b0, KIND_RAM, lo, 8'h00); `CHK("guarded", 8'h11, q);
      cpu(1'b0, KIND_RAM, hi, 8'h00); `CHK("outside", 8'h44, q);
    end
    `CHK("guard silent", n, rstSeen);
    axw(A_AG, 8'h80);
    $display("test ram guard done");
  endtask
  task automatic t_parity;
    n = rstSeen;
    cpu(1'b1, KIND_RAM, RAM_BASE + 20'h10, 8'h5a);
    cpu(1'b0, KIND_RAM, RAM_BASE + 20'h10, 8'h00);
    `CHK("parity data", 8'h5a, q);
    `CHK("parity clean", n, rstSeen);
    badPar <= 1'b1;
    cpu(1'b0, KIND_RAM, RAM_BASE + 20'h10, 8'h00);
    `CHK("parity reset", n + 1, rstSeen);
    cpu(1'b0, KIND_RAM, RAM_BASE + 20'h10, 8'h00, 1'b1);
    `CHK("fetch skips parity", n + 1, rstSeen);
    `CHK("fetch data", 8'h5a, q);
    axr(A_PC); `CHK("parity flag", 8'h01, q);
    axw(A_PC, 8'h80);
    axw(A_PC, 8'h81);
    axr(A_PC); `CHK("flag write one", 8'h80, q);
    cpu(1'b0, KIND_RAM, RAM_BASE + 20'h10, 8'h00);
    badPar <= 1'b0;
    `CHK("reset masked", n + 1, rstSeen);
    axr(A_PC); `CHK("flag masked", 8'h81, q);
    axw(A_PC, 8'h00);
    axr(A_PC); `CHK("flag clear", 8'h00, q);
    axr(A_RC); `CHK("parity cause", 8'h02, q & 8'h02);
    $display("test parity done");
  endtask
  task automatic t_guards;
    access_kind_t kd[3] = '{KIND_PORT_CFG, KIND_IRQ, KIND_SYS_CTRL};
    logic [19:0] a;
    n = rstSeen;
    for (int i = 0; i < 3; i++) begin
      a = 20'hf0020 + 20'(i);
      cpu(1'b1, kd[i], a, 8'h11);
      axw(A_AG, 8'h80 | 8'(4 >> i));
      cpu(1'b1, kd[i], a, 8'h22);
      cpu(1'b1, KIND_PORT_DATA, 20'hf0030, 8'(i));
      cpu(1'b0, kd[i], a, 8'h00); `CHK("guarded sfr", 8'h11, q);
      cpu(1'b0, KIND_PORT_DATA, 20'hf0030, 8'h00);
      `CHK("port data", 8'(i), q);
      axw(A_PC, 8'h80);
      axr(A_PC); `CHK("parity ctl", i == 2 ? 8'h00 : 8'h80, q);
      axw(A_PC, 8'h00);
      axw(A_AG, 8'h80);
      cpu(1'b1, kd[i], a, 8'h33);
      cpu(1'b0, kd[i], a, 8'h00); `CHK("unguarded", 8'h33, q);
    end
    `CHK("guard silent", n, rstSeen);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    axr(A_AG); `CHK("detect after reset", 8'h00, q);
    $display("test sfr guards done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_wdog;
    t_illegal;
    t_ramguard;
    t_parity;
    t_guards;
    final_report;
  end
  // Whole run needs a few hundred cycles; the limit allows 25000
  initial begin
    #100000;
    err_total++;
    final_report;
  end
endmodule

// ---- tb/target_model.sv ----
`timescale 1ns/1ps
module target_model
  import ram_guard_pkg::*;
(
  input  wire logic       clk,
  input  wire ram_req_t   ramReq,
  input  wire sfr_req_t   sfrReq,
  input  wire logic       badParity,
  output      logic [8:0] ramRdata,
  output      logic [7:0] sfrRdata
);
  logic [8:0] mem [4096];
  logic [7:0] sfr [256];
  logic       flip = 1'b0;
  // Read data stands only while the read strobe is out, as the guard
  // samples it at the end of that cycle; idle buses toggle
  assign ramRdata = (ramReq.en && !ramReq.we)
                  ? mem[ramReq.addr] ^ {badParity, 8'h00} : {9{flip}};
  assign sfrRdata = (sfrReq.en && !sfrReq.we)
                  ? sfr[sfrReq.addr[7:0]] : {8{flip}};
  always @(posedge clk) begin
    flip <= ~flip;
    if (ramReq.en && ramReq.we) mem[ramReq.addr] <= ramReq.wdata;
    if (sfrReq.en && sfrReq.we) sfr[sfrReq.addr[7:0]] <= sfrReq.wdata;
  end
endmodule
